// ===== hw/port_ext_pkg.sv
// Constants and types for the parallel/serial and floppy/IDE setup registers.
// Assumes a host configuration port that presents index and data strobes.
package port_ext_pkg;
  localparam logic [7:0] IDX_PARALLEL_SERIAL = 8'h04;
  localparam logic [7:0] IDX_FLOPPY_IDE      = 8'h05;
  localparam logic [7:0] RST_PARALLEL_SERIAL = 8'h00;
  localparam logic [7:0] RST_FLOPPY_IDE      = 8'h00;
  localparam int POS_EXT_MODE   = 0;
  localparam int POS_PP_FLOPPY  = 2;
  localparam int POS_MUSIC_ONE  = 4;
  localparam int POS_MUSIC_TWO  = 5;
  localparam int POS_EPP_REV    = 6;
  localparam int POS_RESERVED   = 7;
  localparam int POS_EXT_DRIVES = 6;
  localparam logic [1:0] EXT_STANDARD = 2'h0;
  localparam logic [1:0] EXT_EPP      = 2'h1;
  localparam logic [1:0] EXT_ECP      = 2'h2;
  localparam logic [1:0] EXT_ECP_EPP  = 2'h3;
  localparam logic [1:0] PPF_NORMAL   = 2'h0;
  localparam logic [1:0] PPF_ONE      = 2'h1;
  localparam logic [1:0] PPF_TWO      = 2'h2;
  localparam logic [2:0] ECR_STANDARD = 3'h0;
  localparam logic [2:0] ECR_EPP      = 3'h4;
  localparam logic [3:0] DIV_NORMAL   = 4'hd;
  localparam logic [3:0] DIV_MUSIC    = 4'hc;
  localparam logic [4:0] OVERSAMPLE   = 5'h10;

  typedef enum logic [2:0] {
    PM_STANDARD, PM_EPP, PM_ECP, PM_ECP_EPP, PM_OFF
  } par_mode_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic       cfgMode;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic       eppActive;
    logic       spPortActive;
    logic       ecpActive;
    logic       ppFloppyOne;
    logic       ppFloppyTwo;
    logic       directTwoOnly;
    logic       eppRev17;
  } par_ctl_t;
endpackage

// ===== hw/port_extended_setup_config.sv
// Extended parallel/serial setup and floppy/IDE setup registers.
// Derived parallel mode, parallel floppy and serial prescaler controls.
// Assumes the configuration port delivers one-cycle strobes with index held.
// Assumes the ECR mode and gate bit come from registers in the same clock.
// Assumes a UART downstream applies the 16x oversampling.
// Behaviour
// - With the gate bit low the mode field picks standard, EPP+standard, ECP or ECP+EPP.
// - The floppy field picks normal, variant one, variant two, and 11 is reserved.
// - Serial one divides its baud clock by 13 normally and by 12 when music is selected.
// - Serial two divides its baud clock by 13 normally and by 12 when music is selected.
// - In ECP+EPP, ECR mode 100 turns on EPP operation.
// - In ECP settings with floppy/IDE bit 6 low only two drives decode directly; more need the external decoder.
// - In ECP settings, ECR mode 000 gives standard parallel operation.
// - In music mode the divide by 12 and 16x oversampling give 125 kbaud from 24 MHz.
// - The floppy/IDE register is reached only in config mode at index 05.
// - The floppy/IDE register resets to 00.
// - The parallel/serial register is reached only in config mode at index 04 and resets to 00.
`timescale 1ns/1ps
module port_extended_setup_config (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire port_ext_pkg::cfg_req_t req,
  input  wire logic                  parGateBit,
  input  wire logic [2:0]            ecrMode,
  output logic [7:0]                 rdata,
  output logic                       rdValid,
  output logic [7:0]                 parallelSerialOut,
  output logic [7:0]                 floppyIdeOut,
  output port_ext_pkg::par_mode_t    parMode,
  output port_ext_pkg::par_ctl_t     parCtl,
  output logic [3:0]                 serialOneDiv,
  output logic [3:0]                 serialTwoDiv,
  output logic                       serialOneTick,
  output logic                       serialTwoTick
);
  import port_ext_pkg::*;

  logic [7:0] psReg_ff;
  logic [7:0] fiReg_ff;
  logic [7:0] rdata_ff;
  logic       rdValid_ff;
  par_mode_t  parMode_ff;
  par_ctl_t   parCtl_ff;
  logic [3:0] divOne_ff;
  logic [3:0] divTwo_ff;
  logic [3:0] cntOne_ff;
  logic [3:0] cntTwo_ff;
  logic       tickOne_ff;
  logic       tickTwo_ff;

  function automatic logic hit(input cfg_req_t r, input logic [7:0] idx);
    return r.cfgMode && (r.index == idx);
  endfunction

  wire logic       psHit    = hit(req, IDX_PARALLEL_SERIAL);
  wire logic       fiHit    = hit(req, IDX_FLOPPY_IDE);
  wire logic [7:0] psWrite  = {1'b0, req.wdata[6:0]};
  wire logic [7:0] nxt_read = psHit ? psReg_ff : (fiHit ? fiReg_ff : 8'h00);
  wire logic [1:0] extMode  = psReg_ff[POS_EXT_MODE +: 2];
  wire logic [1:0] ppfField = psReg_ff[POS_PP_FLOPPY +: 2];
  wire logic       ecpBased = !parGateBit &&
                              (extMode == EXT_ECP || extMode == EXT_ECP_EPP);

  par_mode_t nxt_parMode;
  always_comb begin
    nxt_parMode = PM_OFF;
    if (!parGateBit) begin
      unique case (extMode)
        EXT_STANDARD: nxt_parMode = PM_STANDARD;
        EXT_EPP:      nxt_parMode = PM_EPP;
        EXT_ECP:      nxt_parMode = PM_ECP;
        EXT_ECP_EPP:  nxt_parMode = PM_ECP_EPP;
      endcase
    end
  end

  par_ctl_t nxt_parCtl;
  always_comb begin
    nxt_parCtl = '0;
    nxt_parCtl.ecpActive     = ecpBased;
    nxt_parCtl.eppActive     = (nxt_parMode == PM_EPP) ||
                               ((nxt_parMode == PM_ECP_EPP) &&
                                (ecrMode == ECR_EPP));
    nxt_parCtl.spPortActive  = (nxt_parMode == PM_STANDARD) ||
                               (nxt_parMode == PM_EPP) ||
                               (ecpBased && ecrMode == ECR_STANDARD);
    nxt_parCtl.ppFloppyOne   = (ppfField == PPF_ONE);
    nxt_parCtl.ppFloppyTwo   = (ppfField == PPF_TWO);
    nxt_parCtl.directTwoOnly = ecpBased &&
                               !fiReg_ff[POS_EXT_DRIVES];
    nxt_parCtl.eppRev17      = psReg_ff[POS_EPP_REV];
  end

  function automatic logic [3:0] divPick(input logic music);
    return music ? DIV_MUSIC : DIV_NORMAL;
  endfunction

  wire logic       musicOne    = psReg_ff[POS_MUSIC_ONE];
  wire logic       musicTwo    = psReg_ff[POS_MUSIC_TWO];
  wire logic [3:0] nxt_divOne  = divPick(musicOne);
  wire logic [3:0] nxt_divTwo  = divPick(musicTwo);

  // The prescalers run free and compare against the latched divisor.
  // A divisor cut below the count wraps through the four-bit overflow,
  // so a change costs at most one long period.
  wire logic       endOne      = (cntOne_ff == divOne_ff - 4'h1);
  wire logic       endTwo      = (cntTwo_ff == divTwo_ff - 4'h1);
  wire logic [3:0] nxt_cntOne  = endOne ? 4'h0 : cntOne_ff + 4'h1;
  wire logic [3:0] nxt_cntTwo  = endTwo ? 4'h0 : cntTwo_ff + 4'h1;

  wire logic       nxt_rdValid = req.rdEn && (psHit || fiHit);
  wire logic [7:0] nxt_rdata   = req.rdEn ? nxt_read : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psReg_ff <= RST_PARALLEL_SERIAL;
    end else if (req.wrEn && psHit) begin
      psReg_ff <= psWrite;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fiReg_ff <= RST_FLOPPY_IDE;
    end else if (req.wrEn && fiHit) begin
      fiReg_ff <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= nxt_rdValid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parMode_ff <= PM_STANDARD;
    end else begin
      parMode_ff <= nxt_parMode;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      parCtl_ff <= '0;
    end else begin
      parCtl_ff <= nxt_parCtl;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divOne_ff <= DIV_NORMAL;
    end else begin
      divOne_ff <= nxt_divOne;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divTwo_ff <= DIV_NORMAL;
    end else begin
      divTwo_ff <= nxt_divTwo;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntOne_ff <= 4'h0;
    end else begin
      cntOne_ff <= nxt_cntOne;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntTwo_ff <= 4'h0;
    end else begin
      cntTwo_ff <= nxt_cntTwo;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickOne_ff <= 1'b0;
    end else begin
      tickOne_ff <= endOne;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickTwo_ff <= 1'b0;
    end else begin
      tickTwo_ff <= endTwo;
    end
  end

  assign rdata             = rdata_ff;
  assign rdValid           = rdValid_ff;
  assign parallelSerialOut = psReg_ff;
  assign floppyIdeOut      = fiReg_ff;
  assign parMode           = parMode_ff;
  assign parCtl            = parCtl_ff;
  assign serialOneDiv      = divOne_ff;
  assign serialTwoDiv      = divTwo_ff;
  assign serialOneTick     = tickOne_ff;
  assign serialTwoTick     = tickTwo_ff;
endmodule

// ===== sim/cfg_host.sv
// Host model: packs configuration port strobes into one request.
// Assumes the bench changes its inputs on the falling clock edge.
`timescale 1ns/1ps
module cfg_host (
  input  wire logic             wr,
  input  wire logic             rd,
  input  wire logic             mode,
  input  wire logic [7:0]       idx,
  input  wire logic [7:0]       dat,
  output port_ext_pkg::cfg_req_t req
);
  import port_ext_pkg::*;
  assign req = {wr, rd, mode, idx, dat};
endmodule

// ===== sim/port_ext_properties.sv
// Port checker for the setup register block.
// Assumes it is bound to every instance of the block.
`timescale 1ns/1ps
module port_ext_properties (
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire port_ext_pkg::cfg_req_t req,
  input wire logic                   parGateBit,
  input wire logic [7:0]             rdata,
  input wire logic                   rdValid,
  input wire logic [7:0]             parallelSerialOut,
  input wire logic [7:0]             floppyIdeOut,
  input wire port_ext_pkg::par_mode_t parMode,
  input wire logic [3:0]             serialOneDiv,
  input wire logic [3:0]             serialTwoDiv
);
  import port_ext_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire w = req.wrEn & req.cfgMode;
  a_ps_write: assert property (w && req.index == 8'h04 |=>
    parallelSerialOut == {1'b0, $past(req.wdata[6:0])}) else $error("ps");
  a_fi_write: assert property (w && req.index == 8'h05 |=>
    floppyIdeOut == $past(req.wdata)) else $error("fi");
  a_fi_read: assert property (req.rdEn && req.cfgMode &&
    req.index == 8'h05 |=> rdValid && rdata == $past(floppyIdeOut))
    else $error("rd");
  a_cfg_write_gate: assert property (req.wrEn && !req.cfgMode |=>
    $stable(floppyIdeOut) && $stable(parallelSerialOut)) else $error("wg");
  a_cfg_read_gate: assert property (req.rdEn && !req.cfgMode |=>
    !rdValid && rdata == 8'h00) else $error("rg");
  a_div_one: assert property (serialOneDiv ==
    ($past(parallelSerialOut[4]) ? DIV_MUSIC : DIV_NORMAL)) else $error("d1");
  a_div_two: assert property (serialTwoDiv ==
    ($past(parallelSerialOut[5]) ? DIV_MUSIC : DIV_NORMAL)) else $error("d2");
  a_gate_off: assert property (parGateBit [*2] |=>
    parMode == PM_OFF) else $error("go");
  cover property (w && req.index == 8'h04);
  cover property (serialOneDiv == DIV_MUSIC);
  cover property (parMode == PM_ECP_EPP);
endmodule
bind port_extended_setup_config port_ext_properties chk (.clk(clk),
  .rst_n(rst_n), .req(req), .parGateBit(parGateBit), .rdata(rdata),
  .rdValid(rdValid), .parallelSerialOut(parallelSerialOut),
  .floppyIdeOut(floppyIdeOut), .parMode(parMode),
  .serialOneDiv(serialOneDiv), .serialTwoDiv(serialTwoDiv));

// ===== sim/port_extended_setup_config_tb.sv
// Self-checking bench for the setup register block.
// Assumes the host model packs the strobes it is given.
`timescale 1ns/1ps
module port_extended_setup_config_tb;
  import port_ext_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, mode = 1, gate = 0;
  logic       rdValid, tk1, tk2;
  logic [7:0] idx = 0, dat = 0, rdata, psOut, fiOut;
  logic [2:0] ecr = 0;
  logic [3:0] div1, div2;
  par_mode_t  pm;
  par_ctl_t   ctl;
  cfg_req_t   req;
  int         n_errors = 0, checks = 0, cyc = 0, n;
  cfg_host host (.wr(wr), .rd(rd), .mode(mode), .idx(idx), .dat(dat),
    .req(req));
  port_extended_setup_config uut (.clk(clk), .rst_n(rst_n), .req(req),
    .parGateBit(gate), .ecrMode(ecr), .rdata(rdata), .rdValid(rdValid),
    .parallelSerialOut(psOut), .floppyIdeOut(fiOut), .parMode(pm),
    .parCtl(ctl), .serialOneDiv(div1), .serialTwoDiv(div2),
    .serialOneTick(tk1), .serialTwoTick(tk2));
  initial forever #4 clk = ~clk;
  task chk(logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr_reg(logic [7:0] i, logic [7:0] d);
    @(negedge clk);
    {idx, dat, wr} = {i, d, 1'b1};
    @(negedge clk);
    wr = 0;
    repeat (3) @(negedge clk);
  endtask
  task rd_reg(logic [7:0] i, logic [7:0] e, logic v);
    @(negedge clk);
    {idx, rd} = {i, 1'b1};
    @(negedge clk);
    rd = 0;
    chk(rdata, e);
    chk(8'(rdValid), 8'(v));
  endtask
  task t_access;
    chk(psOut, 8'h00);
    rd_reg(8'h05, 8'h00, 1);
    wr_reg(8'h04, 8'hff);
    rd_reg(8'h04, 8'h7f, 1);
    chk(8'(ctl.eppRev17), 8'h01);
    wr_reg(8'h05, 8'ha5);
    mode = 0;
    wr_reg(8'h05, 8'h00);
    rd_reg(8'h05, 8'h00, 0);
    mode = 1;
    wr_reg(8'h06, 8'h00);
    rd_reg(8'h05, 8'ha5, 1);
    $display("access done");
  endtask
  task t_modes;
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h04, 8'(m));
      chk(8'(pm), 8'(m));
      wr_reg(8'h04, 8'(m << 2));
      chk(8'({ctl.ppFloppyTwo, ctl.ppFloppyOne}), 8'(m == 3 ? 0 : m));
    end
    $display("modes done");
  endtask
  task t_music;
    wr_reg(8'h04, 8'h10);
    chk(8'(div1), 8'h0c);
    chk(8'(div2), 8'h0d);
    wr_reg(8'h04, 8'h20);
    chk(8'(div1), 8'h0d);
    chk(8'(div2), 8'h0c);
    repeat (16) @(negedge clk);
    while (tk2 !== 1'b1) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tk2 !== 1'b1);
    chk(8'(n), 8'h0c);
    while (tk1 !== 1'b1) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tk1 !== 1'b1);
    chk(8'(n), 8'h0d);
    $display("music done");
  endtask
  task t_ecp;
    wr_reg(8'h05, 8'h00);
    ecr = 3'h4;
    wr_reg(8'h04, 8'h03);
    chk(8'(ctl.eppActive), 8'h01);
    chk(8'(ctl.directTwoOnly), 8'h01);
    chk(8'(ctl.ecpActive), 8'h01);
    ecr = 3'h0;
    wr_reg(8'h05, 8'h40);
    chk(8'({ctl.eppActive, ctl.spPortActive}), 8'h01);
    chk(8'(ctl.directTwoOnly), 8'h00);
    gate = 1;
    repeat (3) @(negedge clk);
    chk(8'(pm), 8'(PM_OFF));
    $display("ecp done");
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    t_access;
    t_modes;
    t_music;
    t_ecp;
    complete_run;
  end
endmodule
